/* verilog/startup_init_pin_control.v */
// Start-up sequence, init-complete pin and device-wide overrides
`timescale 1ns/10ps
`include "startup_pins_map.vh"
// Functional notes
// - Unselected optional pin: user I/O, tri-stated pulled-up while configuring
// - User clock option: startup clock paces initialization
// - Init-complete undriven while request low, early
// - Enable bit loaded in first frame: drive low
// - Calibration gating option delays release until done
// - Global output enable low tri-states all I/O except the init-complete pin used as user I/O
// - Global clear low clears all registers
module startup_init_pin_control #(
  parameter INIT_CYCLES = `INIT_CYCLES
) (
  clk,
  srst,
  config_request_n,
  first_frame_valid,
  opt_init_done_in,
  opt_startup_clock_in,
  opt_cal_gate_in,
  opt_global_oe_in,
  opt_global_clear_in,
  startup_clock_in,
  termination_cal_complete,
  global_output_enable_in,
  global_clear_in_n,
  init_user_out,
  init_user_oe,
  init_done_out_r,
  init_done_oe_r,
  init_done_pullup_r,
  user_mode_r,
  configuring_r,
  io_tristate_all_r,
  reg_clear_all_r
);
  input  wire clk;                      // System clock
  input  wire srst;                     // Synchronous reset
  input  wire config_request_n;         // Configuration request, low holds reset
  input  wire first_frame_valid;        // Pulse: first frame option bits valid
  input  wire opt_init_done_in;         // Option: init-complete output enabled
  input  wire opt_startup_clock_in;     // Option: user start-up clock
  input  wire opt_cal_gate_in;          // Option: gate release on calibration
  input  wire opt_global_oe_in;         // Option: global output enable pin
  input  wire opt_global_clear_in;      // Option: global clear pin
  input  wire startup_clock_in;         // User start-up clock, sampled
  input  wire termination_cal_complete; // Calibration done level
  input  wire global_output_enable_in;  // Global output enable pin
  input  wire global_clear_in_n;        // Global clear pin, active low
  input  wire init_user_out;            // User value when pin is user I/O
  input  wire init_user_oe;             // User enable when pin is user I/O
  output wire init_done_out_r;          // Init-complete pin value
  output wire init_done_oe_r;           // Init-complete pin enable
  output wire init_done_pullup_r;       // Weak pull-up on init-complete pin
  output reg  user_mode_r;              // Device in user mode
  output reg  configuring_r;            // Configuration in progress
  output reg  io_tristate_all_r;        // Force all I/O tri-stated
  output reg  reg_clear_all_r;          // Clear all user registers

  localparam [`CNT_W-1:0] INIT_LAST = INIT_CYCLES[`CNT_W-1:0]; // Init step count, cut to counter width

  reg [4:0]        state_r;         // One-hot sequencer state
  reg [4:0]        state_nxt;       // Next state
  reg              opt_done_r;      // Latched init-complete enable bit
  reg              opt_clk_r;       // Latched start-up clock option
  reg              opt_gate_r;      // Latched calibration gating option
  reg              opt_oe_r;        // Latched global OE option
  reg              opt_clr_r;       // Latched global clear option
  reg              drive_low_r;     // Dedicated drive of init-complete
  reg [`CNT_W-1:0] init_cnt_r;      // Initialization step counter
  reg [`SYNC_DEPTH-1:0] uclk_sync_r; // User clock synchroniser
  reg              uclk_prev_r;     // Previous synchronised user clock
  wire             uclk_rise;       // User clock rising edge
  wire             init_step;       // Initialization advances
  wire             cal_ok;          // Calibration gate satisfied

  // Synchronise user start-up clock; edge from second stage only
  always @(posedge clk) begin
    if (srst) begin
      uclk_sync_r <= {`SYNC_DEPTH{`BIT_LO}};
      uclk_prev_r <= `BIT_LO;
    end else begin
      uclk_sync_r <= {uclk_sync_r[`SYNC_DEPTH-2:0], startup_clock_in};
      uclk_prev_r <= uclk_sync_r[`SYNC_DEPTH-1];
    end
  end

  assign uclk_rise = uclk_sync_r[`SYNC_DEPTH-1] & ~uclk_prev_r;
  // Initialization paced by user clock when selected
  assign init_step = opt_clk_r ? uclk_rise : `BIT_HI;
  // Gating applied only when option chosen
  assign cal_ok    = ~opt_gate_r | termination_cal_complete;

  // Next-state logic
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `CFG_IDLE: begin
        // Wait for request release
        if (config_request_n) state_nxt = `CFG_LOAD;
      end
      `CFG_LOAD: begin
        // Option bits arrive with first frame
        if (first_frame_valid) state_nxt = `CFG_INIT;
      end
      `CFG_INIT: begin
        // Count initialization steps
        if (init_step && init_cnt_r == INIT_LAST) state_nxt = `CFG_WAIT;
      end
      `CFG_WAIT: begin
        // Hold until calibration allows release
        if (cal_ok) state_nxt = `CFG_USER;
      end
      `CFG_USER: begin
        // Stay in user mode
        state_nxt = `CFG_USER;
      end
      default: begin
        state_nxt = `CFG_IDLE;
      end
    endcase
    // Request low restarts configuration from any state
    if (!config_request_n) state_nxt = `CFG_IDLE;
  end

  // Sequencer, option latches and counter
  always @(posedge clk) begin
    if (srst) begin
      state_r     <= `CFG_IDLE;
      opt_done_r  <= `BIT_LO;
      opt_clk_r   <= `BIT_LO;
      opt_gate_r  <= `BIT_LO;
      opt_oe_r    <= `BIT_LO;
      opt_clr_r   <= `BIT_LO;
      init_cnt_r  <= `CNT_ZERO;
    end else begin
      state_r <= state_nxt;
      if (state_r == `CFG_IDLE) begin
        // Options forgotten while request is low
        opt_done_r <= `BIT_LO;
        opt_clk_r  <= `BIT_LO;
        opt_gate_r <= `BIT_LO;
        opt_oe_r   <= `BIT_LO;
        opt_clr_r  <= `BIT_LO;
        init_cnt_r <= `CNT_ZERO;
      end else if (state_r == `CFG_LOAD && first_frame_valid) begin
        // Capture option bits
        opt_done_r <= opt_init_done_in;
        opt_clk_r  <= opt_startup_clock_in;
        opt_gate_r <= opt_cal_gate_in;
        opt_oe_r   <= opt_global_oe_in;
        opt_clr_r  <= opt_global_clear_in;
        init_cnt_r <= `CNT_ZERO;
      end else if (state_r == `CFG_INIT && init_step) begin
        // Advance initialization
        init_cnt_r <= init_cnt_r + `CNT_ONE;
      end
    end
  end

  // Init-complete drive and status outputs
  always @(posedge clk) begin
    if (srst) begin
      drive_low_r       <= `BIT_LO;
      user_mode_r       <= `BIT_LO;
      configuring_r     <= `BIT_HI;
      io_tristate_all_r <= `BIT_HI;
      reg_clear_all_r   <= `BIT_HI;
    end else begin
      case (state_nxt)
        `CFG_IDLE, `CFG_LOAD: begin
          // Undriven before option bit is known
          drive_low_r <= `BIT_LO;
        end
        `CFG_INIT, `CFG_WAIT: begin
          // Driven low once enable bit loaded
          drive_low_r <= (state_r == `CFG_LOAD) ? opt_init_done_in : opt_done_r;
        end
        default: begin
          // Released at user mode entry
          drive_low_r <= `BIT_LO;
        end
      endcase
      user_mode_r   <= (state_nxt == `CFG_USER);
      configuring_r <= (state_nxt != `CFG_USER);
      // Output override only in user mode with option set
      io_tristate_all_r <= (state_nxt != `CFG_USER) |
                           (opt_oe_r & ~global_output_enable_in);
      // Clear override only in user mode with option set
      reg_clear_all_r   <= (state_nxt != `CFG_USER) |
                           (opt_clr_r & ~global_clear_in_n);
    end
  end

  // Open-drain init-complete pin with user I/O fallback
  pin_mux_cell init_pin (
    .clk          (clk),
    .srst         (srst),
    .opt_enable   (opt_done_r),
    .configuring  (configuring_r),
    .ded_out      (`BIT_LO),
    .ded_oe       (drive_low_r),
    .user_out     (init_user_out),
    .user_oe      (init_user_oe),
    .pin_out_r    (init_done_out_r),
    .pin_oe_r     (init_done_oe_r),
    .pin_pullup_r (init_done_pullup_r)
  );
endmodule // startup_init_pin_control

/* verilog/startup_pins_map.vh */
// Constants for the start-up and override pin controller
`ifndef STARTUP_PINS_MAP_VH
`define STARTUP_PINS_MAP_VH
`define CFG_IDLE   5'h01
`define CFG_LOAD   5'h02
`define CFG_INIT   5'h04
`define CFG_WAIT   5'h08
`define CFG_USER   5'h10
`define SYNC_DEPTH 2
`define INIT_CYCLES 8
`define CNT_W      8
`define CNT_ZERO   8'h00
`define CNT_ONE    8'h01
`define BIT_LO     1'h0
`define BIT_HI     1'h1
`endif

/* verilog/pin_mux_cell.v */
// One optional pin: dedicated function or user I/O fallback
`timescale 1ns/10ps
module pin_mux_cell (
  clk,
  srst,
  opt_enable,
  configuring,
  ded_out,
  ded_oe,
  user_out,
  user_oe,
  pin_out_r,
  pin_oe_r,
  pin_pullup_r
);
  input  wire clk;          // System clock
  input  wire srst;         // Synchronous reset
  input  wire opt_enable;   // Dedicated function selected
  input  wire configuring;  // Device still configuring
  input  wire ded_out;      // Dedicated output value
  input  wire ded_oe;       // Dedicated output enable
  input  wire user_out;     // User logic output value
  input  wire user_oe;      // User logic output enable
  output reg  pin_out_r;    // Registered pin value
  output reg  pin_oe_r;     // Registered pin enable
  output reg  pin_pullup_r; // Weak pull-up active

  // Select pin source
  always @(posedge clk) begin
    if (srst) begin
      pin_out_r    <= `BIT_LO;
      pin_oe_r     <= `BIT_LO;
      pin_pullup_r <= `BIT_HI;
    end else if (opt_enable) begin
      // Dedicated function owns the pin
      pin_out_r    <= ded_out;
      pin_oe_r     <= ded_oe;
      pin_pullup_r <= `BIT_LO;
    end else if (configuring) begin
      // User I/O tri-stated with pull-up during configuration
      pin_out_r    <= `BIT_LO;
      pin_oe_r     <= `BIT_LO;
      pin_pullup_r <= `BIT_HI;
    end else begin
      // Plain user I/O
      pin_out_r    <= user_out;
      pin_oe_r     <= user_oe;
      pin_pullup_r <= `BIT_LO;
    end
  end
endmodule // pin_mux_cell

/* verif/init_done_monitor.sv */
// Board monitor of the open-drain init-complete pin
`timescale 1ns/10ps
module init_done_monitor (
  input  wire clk,
  input  wire clr,
  input  wire pin_oe,
  input  wire pin_out,
  output wire pin_level,
  output reg  rise_seen_r
);
  reg last_r; // Level at previous edge
  // External pull-up lifts a released line
  assign pin_level = pin_oe ? pin_out : 1'h1;
  // Low-to-high edge marks user mode
  always @(posedge clk) begin
    last_r <= pin_level;
    rise_seen_r <= ~clr & (rise_seen_r | (pin_level & ~last_r));
  end
endmodule // init_done_monitor

/* verif/startup_pins_sva.sv */
// Port assertions for the start-up pin controller
`timescale 1ns/10ps
module startup_pins_sva (
  input wire clk,
  input wire srst,
  input wire config_request_n,
  input wire first_frame_valid,
  input wire opt_init_done_in,
  input wire opt_cal_gate_in,
  input wire opt_global_oe_in,
  input wire termination_cal_complete,
  input wire global_output_enable_in,
  input wire init_done_out_r,
  input wire init_done_oe_r,
  input wire user_mode_r,
  input wire configuring_r,
  input wire io_tristate_all_r,
  input wire reg_clear_all_r
);
  reg init_r; // Options as latched
  reg cal_r;
  reg oe_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Follow the options taken with the frame
  always @(posedge clk) begin
    if (srst)
      {init_r, cal_r, oe_r} <= 3'h0;
    else if (first_frame_valid && configuring_r)
      {init_r, cal_r, oe_r} <= {opt_init_done_in, opt_cal_gate_in, opt_global_oe_in};
  end
  a_forced_off_cfg: assert property (!user_mode_r |-> io_tristate_all_r && reg_clear_all_r)
    else $error("io free outside user mode");
  a_mode_inverse: assert property (configuring_r != user_mode_r)
    else $error("mode flags agree");
  a_restart_idle: assert property (!config_request_n |=> !user_mode_r)
    else $error("user mode kept");
  a_undriven_req: assert property (!config_request_n [*3] |-> !init_done_oe_r)
    else $error("pin driven in request");
  a_drive_low: assert property (first_frame_valid && configuring_r && config_request_n
    && opt_init_done_in |-> ##2 init_done_oe_r && !init_done_out_r) else $error("pin not low");
  a_release_pin: assert property ($rose(user_mode_r) && init_r |=> !init_done_oe_r)
    else $error("pin not released");
  a_stay_released: assert property (user_mode_r && $past(user_mode_r) && init_r |-> !init_done_oe_r)
    else $error("pin driven in user mode");
  a_cal_gate: assert property ($rose(user_mode_r) && cal_r |-> $past(termination_cal_complete))
    else $error("user mode before calibration");
  a_oe_override: assert property (user_mode_r && $past(user_mode_r)
    |-> io_tristate_all_r == (oe_r && !$past(global_output_enable_in))) else $error("bad tristate");
endmodule // startup_pins_sva

/* verif/testbench.sv */
// Random and corner runs of the start-up pin controller
`timescale 1ns/10ps
module testbench;
  reg clk, srst, config_request_n, first_frame_valid, opt_init_done_in, opt_startup_clock_in;
  reg opt_cal_gate_in, opt_global_oe_in, opt_global_clear_in, startup_clock_in, termination_cal_complete;
  reg global_output_enable_in, global_clear_in_n, init_user_out, init_user_oe, urun, mon_clr;
  wire init_done_out_r, init_done_oe_r, init_done_pullup_r, user_mode_r;
  wire configuring_r, io_tristate_all_r, reg_clear_all_r, pin, rise;
  integer seed, bad_count, checked, i, k, n;
  reg [4:0] o; // Options: init, clock, cal, oe, clear
  reg [31:0] rnd; // Raw random word
  startup_init_pin_control #(.INIT_CYCLES(4)) dut (.*);
  init_done_monitor mon (.clk(clk), .clr(mon_clr), .pin_oe(init_done_oe_r), .pin_out(init_done_out_r),
    .pin_level(pin), .rise_seen_r(rise));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // User start-up clock, frozen when urun is low
  always @(posedge clk) startup_clock_in <= startup_clock_in ^ urun;
  task check(input string nm, input seen, input exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected %s expected %b seen %b", nm, exp, seen);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // One configuration pass with options o
  task cfg_run;
    begin
      @(posedge clk);
      {config_request_n, termination_cal_complete, urun, mon_clr} <= 4'h1;
      repeat (3) @(posedge clk);
      #1;
      check("pin oe cfg", init_done_oe_r, 1'h0);
      check("pullup cfg", init_done_pullup_r, 1'h1);
      @(posedge clk);
      {config_request_n, mon_clr} <= 2'h2;
      {opt_init_done_in, opt_startup_clock_in, opt_cal_gate_in, opt_global_oe_in, opt_global_clear_in} <= o;
      @(posedge clk);
      first_frame_valid <= 1'h1;
      @(posedge clk);
      first_frame_valid <= 1'h0;
      @(posedge clk);
      #1;
      check("pin driven low", pin, ~o[4]);
      repeat (20) @(posedge clk);
      #1;
      check("held user mode", user_mode_r, ~(o[3] | o[2]));
      @(posedge clk);
      urun <= 1'h1;
      termination_cal_complete <= o[2];
      for (n = 0; user_mode_r !== 1'h1 && n < 200; n = n + 1) begin
        @(posedge clk);
        #1;
      end
      check("user mode", user_mode_r, 1'h1);
      for (k = 0; k < 4; k = k + 1) begin
        @(posedge clk);
        rnd = $random(seed);
        {global_output_enable_in, global_clear_in_n, init_user_oe, init_user_out} <= rnd[3:0];
        @(posedge clk);
        #1;
        check("tristate", io_tristate_all_r, o[1] & ~global_output_enable_in);
        check("clear", reg_clear_all_r, o[0] & ~global_clear_in_n);
        check("pin oe user", init_done_oe_r, ~o[4] & init_user_oe);
        check("pin out user", init_done_out_r, ~o[4] & init_user_out);
        check("pullup user", init_done_pullup_r, 1'h0);
        if (k == 0)
          check("pin rise", rise, o[4]);
      end
    end
  endtask
  initial begin
    seed = 32'h1338;
    bad_count = 0;
    checked = 0;
    {srst, mon_clr, global_output_enable_in, global_clear_in_n} = 4'hF;
    {config_request_n, first_frame_valid, startup_clock_in, termination_cal_complete, urun} = 5'h00;
    {opt_init_done_in, opt_startup_clock_in, opt_cal_gate_in, opt_global_oe_in, opt_global_clear_in} = 5'h00;
    {init_user_out, init_user_oe, o} = 7'h00;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    #1;
    check("pullup", init_done_pullup_r, 1'h1);
    for (i = 0; i < 12; i = i + 1) begin
      rnd = $random(seed);
      o = (i == 1) ? 5'h1F : (i == 0) ? 5'h00 : rnd[4:0];
      cfg_run;
    end
    end_of_test;
  end
  // Watchdog against a hang
  initial begin
    #100000;
    bad_count = bad_count + 1;
    end_of_test;
  end
endmodule // testbench
bind startup_init_pin_control startup_pins_sva chk (.*);
